// *** core/rotate_subtract_sleep_exec.sv ***
/*
  Executes four instructions of an 8-bit core with 14-bit words:
  rotate-left through carry, literal minus work, file minus work, sleep.
  Also keeps a stand-in watchdog count and prescaler so that the clear on
  sleep can be seen; both run on the core clock and halt while asleep.
  Assumes: one instruction word presented per cycle with i_instr_valid, the
  file operand read combinationally by the core from o_file_addr, the file
  latching the address of the issuing cycle for the write pulse that
  follows, and the core holding instructions while o_sleeping is high.
*/
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "rssx_defs.svh"

// Notes on behaviour
// - rotate left: old carry into bit 0, old bit 7 becomes carry only.
// - destination bit 0 writes work register, 1 writes file register.
// - sleep sets the time-out flag.
// - sleep clears the power-down flag.
// - sleep clears watchdog count and its prescaler.
// - sleep enters sleep mode and stops the main oscillator.
// - literal minus work into work register, updating carry, digit carry, zero.
// - file minus work into destination, updating carry, digit carry, zero.
// - subtract carry is 1 with no borrow, 0 when result negative.
module rotate_subtract_sleep_exec
  import rssx_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_file_rdata,
  input wire logic i_wake,
  output logic [6:0] o_file_addr,
  output logic o_file_we,
  output logic [7:0] o_file_wdata,
  output logic [7:0] o_work,
  output logic o_carry,
  output logic o_digit_carry_flag,
  output logic o_zero,
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic [7:0] o_watchdog_counter,
  output logic [7:0] o_wdt_prescaler,
  output logic o_sleeping,
  output logic o_osc_run,
  output logic o_done
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // returns {carry(no borrow), digit carry(no nibble borrow), diff}
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[`NIBBLE_MSB:0]} + {1'b0, ~b[`NIBBLE_MSB:0]} + 5'h01;
    sub8 = {full[8], low[4], full[7:0]};
  endfunction

  // returns {carry out, rotated byte}
  function automatic logic [8:0] rotl(input logic [7:0] f, input logic c);
    rotl = {f[`BYTE_MSB], f[`BYTE_MSB-1:0], c};
  endfunction

  // sleep word is matched whole first, so no opcode field can shadow it
  function automatic op_kind_type decode_word(input logic [13:0] w);
    decode_word = OPK_NONE;
    if (w == `SLEEP_WORD) begin
      decode_word = OPK_SLEEP;
    end else if (w[`OPC_HI:`OPC_LO] == `OP_ROTATE_LEFT) begin
      decode_word = OPK_ROTATE;
    end else if (w[`OPC_HI:`OPC_LO] == `OP_FILE_MINUS_W) begin
      decode_word = OPK_SUBFIL;
    end else if (w[`OP_LIT_HI:`OP_LIT_LO] == `OP_LIT_MINUS_W_HI) begin
      decode_word = OPK_SUBLIT; // bit 8 is don't-care
    end
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == `ZERO_BYTE);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  op_kind_type kind;
  logic wake_s1_q, wake_s2_q;
  logic [7:0] work_q, file_wdata_q;
  logic carry_q, dc_q, zero_q, to_q, pd_q, sleep_q, we_q, done_q;
  logic [7:0] wdt_q, pre_q;
  logic [9:0] sub_res;
  logic [8:0] rot_res;
  logic dest_file;
  logic dest_write;

  // nothing is taken while asleep: the core clock is notionally stopped
  always_comb begin
    kind = OPK_NONE;
    if (i_instr_valid && !sleep_q) begin
      kind = decode_word(i_instr);
    end
  end

  assign dest_file = i_instr[`DEST_BIT];
  assign dest_write = ((kind == OPK_ROTATE) || (kind == OPK_SUBFIL)) && dest_file;
  assign rot_res = rotl(i_file_rdata, carry_q);
  assign sub_res = (kind == OPK_SUBLIT) ? sub8(i_instr[`LIT_HI:`LIT_LO], work_q)
                                        : sub8(i_file_rdata, work_q);
  // combinational: the operand must be read in the issuing cycle
  assign o_file_addr = i_instr[`FADDR_HI:`FADDR_LO];

  // ----------------------------------------------------------------
  // wake input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_s1_q <= `FLAG_CLEAR;
      wake_s2_q <= `FLAG_CLEAR;
    end else begin
      wake_s1_q <= i_wake;
      wake_s2_q <= wake_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // working register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      work_q <= `WORK_RESET;
    end else begin
      case (kind)
        OPK_ROTATE: begin
          if (!dest_file) begin
            work_q <= rot_res[`BYTE_MSB:0];
          end
        end
        OPK_SUBFIL: begin
          if (!dest_file) begin
            work_q <= sub_res[`BYTE_MSB:0];
          end
        end
        OPK_SUBLIT: begin
          work_q <= sub_res[`BYTE_MSB:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // file write-back
  // ----------------------------------------------------------------
  // one-cycle pulse; the file keeps the address of the issuing cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      we_q <= `FLAG_CLEAR;
    end else begin
      we_q <= dest_write;
    end
  end

  // data only moves on a write, so it stays readable after the pulse
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      file_wdata_q <= `WORK_RESET;
    end else begin
      case (kind)
        OPK_ROTATE: begin
          if (dest_file) begin
            file_wdata_q <= rot_res[`BYTE_MSB:0];
          end
        end
        OPK_SUBFIL: begin
          if (dest_file) begin
            file_wdata_q <= sub_res[`BYTE_MSB:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // arithmetic flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      carry_q <= `FLAG_CLEAR;
    end else begin
      case (kind)
        OPK_ROTATE: begin
          carry_q <= rot_res[`BYTE_MSB+1];
        end
        OPK_SUBLIT, OPK_SUBFIL: begin
          carry_q <= sub_res[`SUB_C_BIT];
        end
        default: ;
      endcase
    end
  end

  // rotate leaves digit carry and zero alone
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dc_q <= `FLAG_CLEAR;
    end else begin
      case (kind)
        OPK_SUBLIT, OPK_SUBFIL: begin
          dc_q <= sub_res[`SUB_DC_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      zero_q <= `FLAG_CLEAR;
    end else begin
      case (kind)
        OPK_SUBLIT, OPK_SUBFIL: begin
          zero_q <= is_zero(sub_res[`BYTE_MSB:0]);
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power-down status and sleep
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      to_q <= `TIMEOUT_RESET;
    end else if (kind == OPK_SLEEP) begin
      to_q <= `FLAG_SET;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pd_q <= `POWERDOWN_RESET;
    end else if (kind == OPK_SLEEP) begin
      pd_q <= `FLAG_CLEAR;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sleep_q <= `FLAG_CLEAR;
    end else if (kind == OPK_SLEEP) begin
      sleep_q <= `FLAG_SET;
    end else if (sleep_q && wake_s2_q) begin
      // wake handling proper lives elsewhere; this only restarts the clock
      sleep_q <= `FLAG_CLEAR;
    end
  end

  // ----------------------------------------------------------------
  // stand-in watchdog count and prescaler
  // ----------------------------------------------------------------
  // limitation: runs on the core clock, so it halts in sleep and can
  // never wake the core; it exists so that the clear is observable
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pre_q <= `PRESCALE_CLEAR;
    end else if (kind == OPK_SLEEP) begin
      pre_q <= `PRESCALE_CLEAR;
    end else if (!sleep_q) begin
      pre_q <= pre_q + `COUNT_STEP;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wdt_q <= `WDT_CLEAR;
    end else if (kind == OPK_SLEEP) begin
      wdt_q <= `WDT_CLEAR;
    end else if (!sleep_q && (pre_q == `PRESCALE_LAST)) begin
      wdt_q <= wdt_q + `COUNT_STEP;
    end
  end

  // ----------------------------------------------------------------
  // completion strobe: one cycle per accepted instruction
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_q <= `FLAG_CLEAR;
    end else begin
      done_q <= (kind != OPK_NONE);
    end
  end

  assign o_work = work_q;
  assign o_file_we = we_q;
  assign o_file_wdata = file_wdata_q;
  assign o_carry = carry_q;
  assign o_digit_carry_flag = dc_q;
  assign o_zero = zero_q;
  assign o_timeout_flag = to_q;
  assign o_powerdown_flag = pd_q;
  assign o_watchdog_counter = wdt_q;
  assign o_wdt_prescaler = pre_q;
  assign o_sleeping = sleep_q;
  assign o_osc_run = ~sleep_q;
  assign o_done = done_q;

endmodule

// *** core/rssx_defs.svh ***
/*
  Shared constants for the rotate/subtract/sleep execution block:
  opcode fields, fixed words, flag reset values.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef RSSX_DEFS_SVH
`define RSSX_DEFS_SVH

`define OPC_HI 13
`define OPC_LO 8
`define OP_ROTATE_LEFT 6'h0d
`define OP_FILE_MINUS_W 6'h02
`define OP_LIT_MINUS_W_HI 5'h1e
`define OP_LIT_HI 13
`define OP_LIT_LO 9
`define SLEEP_WORD 14'h0063
`define DEST_BIT 7
`define FADDR_HI 6
`define FADDR_LO 0
`define LIT_HI 7
`define LIT_LO 0
`define BYTE_MSB 7
`define NIBBLE_MSB 3
`define WORK_RESET 8'h00
`define WDT_CLEAR 8'h00
`define PRESCALE_CLEAR 8'h00
`define PRESCALE_LAST 8'hff
`define COUNT_STEP 8'h01
`define ZERO_BYTE 8'h00
`define SUB_C_BIT 9
`define SUB_DC_BIT 8
`define FLAG_SET 1'b1
`define FLAG_CLEAR 1'b0
`define TIMEOUT_RESET 1'b1
`define POWERDOWN_RESET 1'b1

`endif

// *** core/rssx_pkg.sv ***
/*
  Types for the execution block. Assumes rssx_defs.svh on the include path.
*/
`include "rssx_defs.svh"
package rssx_pkg;
  typedef enum logic [4:0] {
    OPK_NONE   = 5'h01,
    OPK_ROTATE = 5'h02,
    OPK_SUBLIT = 5'h04,
    OPK_SUBFIL = 5'h08,
    OPK_SLEEP  = 5'h10
  } op_kind_type;
endpackage

// *** verif/rotate_subtract_sleep_exec_test.sv ***
/* Directed bench for the exec block; drives all its ports itself. */
`timescale 1ns/100ps
module rotate_subtract_sleep_exec_test;
  logic i_ref_clk = 0, i_resetn = 0, i_instr_valid = 0, i_wake = 0;
  logic [13:0] i_instr = 14'h0000;
  logic [7:0] i_file_rdata = 8'h00, o_file_wdata, o_work, o_watchdog_counter, o_wdt_prescaler;
  logic [6:0] o_file_addr;
  logic o_file_we, o_carry, o_digit_carry_flag, o_zero, o_timeout_flag, o_powerdown_flag;
  logic o_sleeping, o_osc_run, o_done;
  int fail_count = 0, checked = 0, cycles = 0;
  logic [7:0] w;
  always #10 i_ref_clk = ~i_ref_clk;
  rotate_subtract_sleep_exec u_rotate_subtract_sleep_exec (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .i_file_rdata(i_file_rdata),
    .i_wake(i_wake),
    .o_file_addr(o_file_addr),
    .o_file_we(o_file_we),
    .o_file_wdata(o_file_wdata),
    .o_work(o_work),
    .o_carry(o_carry),
    .o_digit_carry_flag(o_digit_carry_flag),
    .o_zero(o_zero),
    .o_timeout_flag(o_timeout_flag),
    .o_powerdown_flag(o_powerdown_flag),
    .o_watchdog_counter(o_watchdog_counter),
    .o_wdt_prescaler(o_wdt_prescaler),
    .o_sleeping(o_sleeping),
    .o_osc_run(o_osc_run),
    .o_done(o_done)
  );
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task run(input logic [13:0] ins, input logic [7:0] rd);
    @(posedge i_ref_clk);
    i_instr <= ins;
    i_file_rdata <= rd;
    i_instr_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_instr_valid <= 1'b0;
    i_file_rdata <= ~rd; // stale operand must not leak into results
    #1;
  endtask
  task sub_lit(input logic [7:0] k, input logic b);
    logic [7:0] r;
    r = k - w;
    run({5'h1e, b, k}, 8'h00);
    chk(o_work, r);
    chk1(o_carry, k >= w);
    chk1(o_digit_carry_flag, k[3:0] >= w[3:0]);
    chk1(o_zero, r == 8'h00);
    chk1(o_done, 1'b1);
    w = r;
  endtask
  task set_w(input logic [7:0] v);
    sub_lit(v + w, 1'b0);
  endtask
  task test_sublit;
    logic [7:0] wv[5], kv[5];
    wv = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h0f};
    kv = '{8'h02, 8'h02, 8'h02, 8'h10, 8'h1f};
    for (int i = 0; i < 5; i++) begin
      set_w(wv[i]);
      sub_lit(kv[i], i[0]);
    end
  endtask
  task test_subfil;
    set_w(8'h02);
    run({6'h02, 1'b1, 7'h15}, 8'h03);
    chk1(o_file_we, 1'b1);
    chk(o_file_wdata, 8'h01);
    chk({1'b0, o_file_addr}, 8'h15);
    chk1(o_carry, 1'b1);
    chk1(o_digit_carry_flag, 1'b1);
    chk1(o_zero, 1'b0);
    chk(o_work, 8'h02);
    run({6'h02, 1'b0, 7'h15}, 8'h01);
    chk1(o_file_we, 1'b0);
    chk(o_work, 8'hff);
    chk1(o_carry, 1'b0);
    chk1(o_digit_carry_flag, 1'b0);
    w = 8'hff;
  endtask
  task test_rotate;
    run({6'h0d, 1'b1, 7'h21}, 8'he6);
    chk1(o_file_we, 1'b1);
    chk(o_file_wdata, 8'hcc);
    chk1(o_carry, 1'b1);
    chk(o_work, w);
    run({6'h0d, 1'b0, 7'h21}, 8'h01);
    chk(o_work, 8'h03);
    chk1(o_carry, 1'b0);
    chk1(o_done, 1'b1);
    w = 8'h03;
  endtask
  task test_sleep;
    repeat (300) @(posedge i_ref_clk);
    #1;
    chk1(o_watchdog_counter != 8'h00, 1'b1);
    run(14'h0063, 8'h00);
    chk1(o_done, 1'b1);
    chk1(o_timeout_flag, 1'b1);
    chk1(o_powerdown_flag, 1'b0);
    chk(o_watchdog_counter, 8'h00);
    chk(o_wdt_prescaler, 8'h00);
    chk1(o_sleeping, 1'b1);
    chk1(o_osc_run, 1'b0);
    run({5'h1e, 1'b0, 8'h55}, 8'h00);
    chk1(o_done, 1'b0);
    chk(o_work, w);
    chk(o_wdt_prescaler, 8'h00);
    @(posedge i_ref_clk);
    i_wake <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk1(o_sleeping, 1'b1);
    @(posedge i_ref_clk);
    i_wake <= 1'b0;
    #1;
    chk1(o_sleeping, 1'b0);
    chk1(o_osc_run, 1'b1);
    run(14'h0062, 8'h00);
    chk1(o_done, 1'b0);
  endtask
  task test_done;
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    w = 8'h00;
    test_sublit();
    test_subfil();
    test_rotate();
    test_sleep();
    test_done();
  end
endmodule

// *** verif/rssx_chk.sv ***
/* Assertion checker for the exec block; sees only its top ports, bound below. */
`timescale 1ns/100ps
module rssx_chk (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_instr_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_file_rdata,
  input wire logic o_file_we,
  input wire logic [7:0] o_file_wdata,
  input wire logic [7:0] o_work,
  input wire logic o_carry,
  input wire logic o_digit_carry_flag,
  input wire logic o_timeout_flag,
  input wire logic o_powerdown_flag,
  input wire logic [7:0] o_watchdog_counter,
  input wire logic [7:0] o_wdt_prescaler,
  input wire logic o_sleeping,
  input wire logic o_osc_run,
  input wire logic o_done
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic go, rot, fil, lit, slp;
  assign go = i_instr_valid && !o_sleeping;
  assign rot = go && i_instr[13:8] == 6'h0d;
  assign fil = go && i_instr[13:8] == 6'h02;
  assign lit = go && i_instr[13:9] == 5'h1e;
  assign slp = go && i_instr == 14'h0063;
  a_rotate_wdata: assert property (
    rot && i_instr[7] |=> o_file_wdata == {$past(i_file_rdata[6:0]), $past(o_carry)})
    else $error("rotate write data wrong");
  a_rotate_carry: assert property (rot |=> o_carry == $past(i_file_rdata[7]))
    else $error("rotate carry wrong");
  a_dest_select: assert property ((rot || fil) |=> o_file_we == $past(i_instr[7]))
    else $error("destination wrong");
  a_sleep_status: assert property (slp |=> o_timeout_flag && !o_powerdown_flag)
    else $error("sleep status wrong");
  a_sleep_wdt: assert property (slp |=> o_watchdog_counter == 8'h00 && o_wdt_prescaler == 8'h00)
    else $error("watchdog not cleared");
  a_sleep_osc: assert property (slp |=> o_sleeping && !o_osc_run)
    else $error("sleep mode wrong");
  a_lit_result: assert property (lit |=> o_work == $past(i_instr[7:0]) - $past(o_work))
    else $error("literal subtract wrong");
  a_file_result: assert property (
    fil && i_instr[7] |=> o_file_wdata == $past(i_file_rdata) - $past(o_work))
    else $error("file subtract wrong");
  a_borrow_carry: assert property (
    lit |=> o_carry == ($past(i_instr[7:0]) >= $past(o_work))) else $error("borrow wrong");
  a_one_cycle: assert property ((rot || fil || lit || slp) |=> o_done)
    else $error("no completion");
  a_lit_digit: assert property (
    lit |=> o_digit_carry_flag == ($past(i_instr[3:0]) >= $past(o_work[3:0])))
    else $error("digit carry wrong");
  a_file_work: assert property (
    fil && !i_instr[7] |=> o_work == $past(i_file_rdata) - $past(o_work))
    else $error("file subtract to work wrong");
  a_refuse_asleep: assert property (i_instr_valid && o_sleeping |=> !o_done)
    else $error("instruction taken while asleep");
  a_prescale_run: assert property (
    i_resetn && o_osc_run && !slp |=> o_wdt_prescaler == $past(o_wdt_prescaler) + 8'h01)
    else $error("prescaler not counting");
endmodule

bind rotate_subtract_sleep_exec rssx_chk u_rssx_chk (
  .i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn),
  .i_instr_valid(i_instr_valid),
  .i_instr(i_instr),
  .i_file_rdata(i_file_rdata),
  .o_file_we(o_file_we),
  .o_file_wdata(o_file_wdata),
  .o_work(o_work),
  .o_carry(o_carry),
  .o_digit_carry_flag(o_digit_carry_flag),
  .o_timeout_flag(o_timeout_flag),
  .o_powerdown_flag(o_powerdown_flag),
  .o_watchdog_counter(o_watchdog_counter),
  .o_wdt_prescaler(o_wdt_prescaler),
  .o_sleeping(o_sleeping),
  .o_osc_run(o_osc_run),
  .o_done(o_done)
);
